// ===== hcoc_pkg.sv
// Purpose: Shared constants and types for the handler custom output combiner
// Assumes: AHB-Lite register access, 32-bit words, single clock CLK_SYS
// Notes: Judgement bit n-1 carries the condition selected by operand code n
// Functional notes
// - Two output lines, each fully separately configured
// - Polarity code 1 active low, 2 high; readable
// - First operand: 1-8 bins, 9-13 out/hi/lo/pass/fail
// - Second operand uses the same thirteen codes
// - Operator code 2 ANDs, code 3 ORs
// - Operator code 1 uses first operand only
package hcoc_pkg;

  // Register byte offsets
  localparam logic [31:0] OFS_LINE1_CFG = 32'h0000_0000;
  localparam logic [31:0] OFS_LINE2_CFG = 32'h0000_0004;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0008;

  // Configuration register field positions
  localparam int FLD_FIRST_LSB = 0;
  localparam int FLD_SECOND_LSB = 4;
  localparam int FLD_OPER_LSB = 8;
  localparam int FLD_POL_LSB = 10;

  // Status register field positions
  localparam int FLD_JUDGE_LSB = 0;
  localparam int FLD_LINES_LSB = 16;

  // Operand codes: valid range
  localparam logic [3:0] SEL_MIN = 4'h1;
  localparam logic [3:0] SEL_MAX = 4'hd;

  // Combining operator codes
  localparam logic [1:0] OPER_OFF = 2'h1;
  localparam logic [1:0] OPER_AND = 2'h2;
  localparam logic [1:0] OPER_OR = 2'h3;

  // Polarity codes
  localparam logic [1:0] POL_LOW = 2'h1;
  localparam logic [1:0] POL_HIGH = 2'h2;

  // Reset values of a line configuration
  localparam logic [3:0] RST_FIRST = 4'h1;
  localparam logic [3:0] RST_SECOND = 4'h1;
  localparam logic [1:0] RST_OPER = 2'h1;
  localparam logic [1:0] RST_POL = 2'h2;

  // Number of judgement conditions and of output lines
  localparam int JUDGE_W = 13;
  localparam int LINES = 2;

  // Judgement vector: bins 1-8, bin-out, high, low, pass, fail
  typedef logic [JUDGE_W-1:0] hcoc_judge_type;

  // One output line's settings
  typedef struct packed {
    logic [1:0] pol;
    logic [1:0] oper;
    logic [3:0] second_operand_select;
    logic [3:0] first_operand_select;
  } hcoc_line_cfg_type;

  // Pick the condition named by an operand code; bad codes give false
  function automatic logic hcoc_pick(logic [3:0] code, hcoc_judge_type j);
    logic [3:0] idx;
    idx = code - SEL_MIN;
    if (code >= SEL_MIN && code <= SEL_MAX)
      return j[idx];
    return 1'b0;
  endfunction : hcoc_pick

endpackage : hcoc_pkg

// ===== hcoc_line_eval.sv
// Purpose: Combine two selected judgement conditions for one output line
// Assumes: Settings already hold legal codes
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ps
module hcoc_line_eval (
  // Settings of this line
  input wire hcoc_pkg::hcoc_line_cfg_type cfg,
  // Latched judgement
  input wire hcoc_pkg::hcoc_judge_type judge,
  // Line level before the output flop
  output logic level
);

  logic op_a; // First operand condition
  logic op_b; // Second operand condition
  logic cond; // Combined condition

  // Operand decode, combine, then polarity
  always_comb
  begin
    op_a = hcoc_pkg::hcoc_pick(cfg.first_operand_select, judge);
    op_b = hcoc_pkg::hcoc_pick(cfg.second_operand_select, judge);
    case (cfg.oper)
      hcoc_pkg::OPER_AND: cond = op_a & op_b;
      hcoc_pkg::OPER_OR: cond = op_a | op_b;
      default: cond = op_a;
    endcase
    // Active low drives the line low when the condition holds
    if (cfg.pol == hcoc_pkg::POL_LOW)
      level = ~cond;
    else
      level = cond;
  end

endmodule : hcoc_line_eval

// ===== hcoc_combiner.sv
// Purpose: Two handler output lines built from selectable judgements
// Assumes: AHB-Lite slave, zero wait states, word transfers only
// Notes: Lines follow a new judgement two edges after its strobe
`timescale 1ns/1ps
module hcoc_combiner (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Judgement results from the measurement engine
  input wire logic JUDGE_VALID,
  input wire hcoc_pkg::hcoc_judge_type JUDGE_RESULT,
  // Handler output lines
  output logic [1:0] USER_OUT
);

  // Register selector codes
  typedef enum logic [3:0] {
    SEL_CFG1 = 4'b0001,
    SEL_CFG2 = 4'b0010,
    SEL_STAT = 4'b0100,
    SEL_NONE = 4'b1000
  } hcoc_sel_type;

  // Whole module state
  typedef struct packed {
    hcoc_pkg::hcoc_line_cfg_type [hcoc_pkg::LINES-1:0] cfg;
    hcoc_pkg::hcoc_judge_type judge;
    logic [1:0] lines;
    logic [31:0] rdata;
    logic ready;
    logic wr_pend;
    hcoc_sel_type wr_sel;
  } hcoc_state_type;

  hcoc_state_type st_reg; // Registered state
  hcoc_state_type st_next; // Next state
  logic [1:0] line_level; // Evaluated line levels
  hcoc_sel_type rd_sel; // Address phase decode
  logic [31:0] rd_word; // Read mux result

  // Address decode, used for both reads and writes
  function automatic hcoc_sel_type decode(logic [31:0] addr);
    logic [31:0] word;
    word = {addr[31:2], 2'b00};
    if (word == hcoc_pkg::OFS_LINE1_CFG)
      return SEL_CFG1;
    if (word == hcoc_pkg::OFS_LINE2_CFG)
      return SEL_CFG2;
    if (word == hcoc_pkg::OFS_STATUS)
      return SEL_STAT;
    return SEL_NONE;
  endfunction : decode

  // Field-wise update: an illegal code leaves that field unchanged
  function automatic hcoc_pkg::hcoc_line_cfg_type merge(
    hcoc_pkg::hcoc_line_cfg_type old, logic [31:0] wd);
    hcoc_pkg::hcoc_line_cfg_type n;
    logic [3:0] f;
    logic [3:0] s;
    logic [1:0] o;
    logic [1:0] p;
    n = old;
    f = wd[hcoc_pkg::FLD_FIRST_LSB +: 4];
    s = wd[hcoc_pkg::FLD_SECOND_LSB +: 4];
    o = wd[hcoc_pkg::FLD_OPER_LSB +: 2];
    p = wd[hcoc_pkg::FLD_POL_LSB +: 2];
    if (f >= hcoc_pkg::SEL_MIN && f <= hcoc_pkg::SEL_MAX)
      n.first_operand_select = f;
    if (s >= hcoc_pkg::SEL_MIN && s <= hcoc_pkg::SEL_MAX)
      n.second_operand_select = s;
    if (o != 2'h0)
      n.oper = o;
    if (p == hcoc_pkg::POL_LOW || p == hcoc_pkg::POL_HIGH)
      n.pol = p;
    return n;
  endfunction : merge

  // Config as software reads it back
  function automatic logic [31:0] cfg_word(hcoc_pkg::hcoc_line_cfg_type c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[hcoc_pkg::FLD_FIRST_LSB +: 4] = c.first_operand_select;
    w[hcoc_pkg::FLD_SECOND_LSB +: 4] = c.second_operand_select;
    w[hcoc_pkg::FLD_OPER_LSB +: 2] = c.oper;
    w[hcoc_pkg::FLD_POL_LSB +: 2] = c.pol;
    return w;
  endfunction : cfg_word

  // One evaluator per line, each with its own settings
  for (genvar i = 0; i < hcoc_pkg::LINES; i++)
  begin : g_line
    hcoc_line_eval u_eval (
      .cfg(st_reg.cfg[i]),
      .judge(st_reg.judge),
      .level(line_level[i])
    );
  end

  // Next state: write data phase, judgement capture, read address phase
  always_comb
  begin
    st_next = st_reg;
    st_next.wr_pend = 1'b0;
    st_next.ready = 1'b1;
    rd_sel = decode(HADDR);
    // Data phase of a write lands in the selected line
    if (st_reg.wr_pend)
    begin
      case (st_reg.wr_sel)
        SEL_CFG1: st_next.cfg[0] = merge(st_reg.cfg[0], HWDATA);
        SEL_CFG2: st_next.cfg[1] = merge(st_reg.cfg[1], HWDATA);
        default: ; // Status and holes ignore writes
      endcase
    end
    // New judgement replaces the previous one
    if (JUDGE_VALID)
      st_next.judge = JUDGE_RESULT;
    // Lines always reflect the latest judgement and settings
    st_next.lines = line_level;
    // Read mux sees a write from the previous transfer already
    case (rd_sel)
      SEL_CFG1: rd_word = cfg_word(st_next.cfg[0]);
      SEL_CFG2: rd_word = cfg_word(st_next.cfg[1]);
      SEL_STAT:
      begin
        rd_word = 32'h0000_0000;
        rd_word[hcoc_pkg::FLD_JUDGE_LSB +: hcoc_pkg::JUDGE_W] = st_reg.judge;
        rd_word[hcoc_pkg::FLD_LINES_LSB +: 2] = st_reg.lines;
      end
      default: rd_word = 32'h0000_0000;
    endcase
    // Address phase accepted when the bus is ready
    if (HSEL && HTRANS[1] && HREADY)
    begin
      if (HWRITE)
      begin
        st_next.wr_pend = 1'b1;
        st_next.wr_sel = rd_sel;
      end
      else
        st_next.rdata = rd_word;
    end
  end

  // State register; reset leaves both lines at their inactive level
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      for (int i = 0; i < hcoc_pkg::LINES; i++)
      begin
        st_reg.cfg[i].first_operand_select <= hcoc_pkg::RST_FIRST;
        st_reg.cfg[i].second_operand_select <= hcoc_pkg::RST_SECOND;
        st_reg.cfg[i].oper <= hcoc_pkg::RST_OPER;
        st_reg.cfg[i].pol <= hcoc_pkg::RST_POL;
      end
      st_reg.judge <= '0;
      st_reg.lines <= 2'h0;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.ready <= 1'b1;
      st_reg.wr_pend <= 1'b0;
      st_reg.wr_sel <= SEL_NONE;
    end
    else
      st_reg <= st_next;
  end

  // Outputs straight from flops; response is always OKAY
  assign HRDATA = st_reg.rdata;
  assign HREADYOUT = st_reg.ready;
  assign HRESP = 1'b0;
  assign USER_OUT = st_reg.lines;

  // Reference model, written apart from the evaluator on purpose
  function automatic logic ref_level(hcoc_pkg::hcoc_line_cfg_type c,
    hcoc_pkg::hcoc_judge_type j);
    logic a;
    logic b;
    logic r;
    a = j[c.first_operand_select - 4'h1];
    b = j[c.second_operand_select - 4'h1];
    r = (c.oper == hcoc_pkg::OPER_AND) ? (a & b) :
        (c.oper == hcoc_pkg::OPER_OR) ? (a | b) : a;
    return (c.pol == hcoc_pkg::POL_LOW) ? ~r : r;
  endfunction : ref_level

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // A judgement shows on both lines two edges later
  a_judge_reeval: assert property (
    JUDGE_VALID ##1 !st_reg.wr_pend |=>
    USER_OUT == {ref_level($past(st_reg.cfg[1]), $past(JUDGE_RESULT, 2)),
                 ref_level($past(st_reg.cfg[0]), $past(JUDGE_RESULT, 2))})
    else $error("lines do not follow the new judgement");
  a_line_indep: assert property (
    !st_reg.wr_pend && $stable(st_reg.judge)
    && st_reg.cfg[0] == st_reg.cfg[1] |=> USER_OUT[0] == USER_OUT[1])
    else $error("equal lines disagree");
  // Line 2 is where the OR, AND and active-low settings get exercised
  a_pol_low: assert property (
    !st_reg.wr_pend
    && st_reg.cfg[1].pol == hcoc_pkg::POL_LOW
    && st_reg.cfg[1].oper == hcoc_pkg::OPER_OFF
    && st_reg.judge[st_reg.cfg[1].first_operand_select - 4'h1] |=>
    !USER_OUT[1]) else $error("active low line not low");
  a_pol_readback: assert property (
    HSEL && HTRANS[1] && !HWRITE && HREADY
    && decode(HADDR) == SEL_CFG1 && !st_reg.wr_pend |=>
    HRDATA[hcoc_pkg::FLD_POL_LSB +: 2] == $past(st_reg.cfg[0].pol))
    else $error("polarity read back wrong");
  a_first_sel: assert property (
    !st_reg.wr_pend
    && st_reg.cfg[0].pol == hcoc_pkg::POL_HIGH
    && st_reg.cfg[0].oper == hcoc_pkg::OPER_OFF |=> USER_OUT[0] ==
    $past(st_reg.judge[st_reg.cfg[0].first_operand_select - 4'h1]))
    else $error("first operand decode wrong");
  a_second_sel: assert property (
    !st_reg.wr_pend
    && st_reg.cfg[1].pol == hcoc_pkg::POL_HIGH
    && st_reg.cfg[1].oper == hcoc_pkg::OPER_AND
    && st_reg.judge[st_reg.cfg[1].first_operand_select - 4'h1] |=>
    USER_OUT[1] ==
    $past(st_reg.judge[st_reg.cfg[1].second_operand_select - 4'h1]))
    else $error("second operand decode wrong");
  a_or_oper: assert property (
    !st_reg.wr_pend
    && st_reg.cfg[1].pol == hcoc_pkg::POL_HIGH
    && st_reg.cfg[1].oper == hcoc_pkg::OPER_OR
    && !st_reg.judge[st_reg.cfg[1].first_operand_select - 4'h1]
    && st_reg.judge[st_reg.cfg[1].second_operand_select - 4'h1] |=>
    USER_OUT[1]) else $error("or operator not asserted");
  a_off_ignore: assert property (
    !st_reg.wr_pend
    && st_reg.cfg[1].oper == hcoc_pkg::OPER_OFF |=> USER_OUT[1] ==
    ($past(st_reg.judge[st_reg.cfg[1].first_operand_select - 4'h1])
     ^ ($past(st_reg.cfg[1].pol) == hcoc_pkg::POL_LOW)))
    else $error("off operator looked at second operand");

  // Main scenarios
  c_judge: cover property (JUDGE_VALID ##2 USER_OUT == 2'b11);
  c_cfg2_write: cover property (st_reg.wr_pend && st_reg.wr_sel == SEL_CFG2);
  c_stat_read: cover property (HSEL && HTRANS[1] && !HWRITE
    && decode(HADDR) == SEL_STAT);

endmodule : hcoc_combiner

// ===== hcoc_handler_model.sv
// Purpose: Handler side that reads the two user output lines
// Assumes: The handler samples line levels on the rising clock edge
// Notes: Observer only; a real handler never drives these lines
`timescale 1ns/1ps
module hcoc_handler_model (
  // Clock
  input wire logic clk,
  // Lines from the device
  input wire logic [1:0] lines,
  // Levels as the handler last saw them
  output logic [1:0] seen
);
  // One sample per edge, like a strobed handler input
  always_ff @(posedge clk)
  begin
    seen <= lines;
  end
endmodule : hcoc_handler_model

// ===== tb_handler_custom_output_combiner.sv
// Purpose: Self-checking bench for the handler output combiner
// Assumes: Zero wait-state slave; lines follow a judgement in two edges
// Notes: Line checks go through the handler model, one edge late
`timescale 1ns/1ps
module tb_handler_custom_output_combiner;
  // Clock, reset and bus
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  // Judgement and lines
  logic judge_valid = 1'b0;
  hcoc_pkg::hcoc_judge_type judge_result = '0;
  logic [1:0] user_out;
  logic [1:0] seen;
  // Bookkeeping
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] exp;
  logic a, b, cond;

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  // Single slave, so its ready is the bus ready
  hcoc_combiner DUT (.CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .JUDGE_VALID(judge_valid),
    .JUDGE_RESULT(judge_result), .USER_OUT(user_out));

  // Handler on the far side of the lines
  hcoc_handler_model handler (.clk(clk_sys), .lines(user_out),
    .seen(seen));

  // Compare and report a mismatch at once
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want)
    begin
      miscompares++;
      $display("FAIL %0t got %h want %h", $time, got, want);
    end
  endtask : check

  // One single word transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [31:0] ad,
                     input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    // Response is always OKAY
    check({31'h0, hresp}, 32'h0);
  endtask : ahb

  // Pulse a judgement, then check what the handler saw
  task automatic judge(input logic [12:0] j, input logic [1:0] want);
    @(posedge clk_sys);
    judge_valid <= 1'b1;
    judge_result <= j;
    @(posedge clk_sys);
    judge_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 check({30'h0, seen}, {30'h0, want});
  endtask : judge

  // Line settings word: polarity, operator, second, first
  function automatic logic [31:0] cfg(input logic [3:0] f, s,
                                      input logic [1:0] o, p);
    return {20'h0, p, o, s, f};
  endfunction : cfg

  // Verdict and end of run
  task automatic summarize;
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // Hang guard, well above the roughly 400 cycles needed
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      miscompares++;
      summarize();
    end
  end

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset settings and idle line levels
    ahb(1'b0, hcoc_pkg::OFS_LINE1_CFG, 32'h0);
    check(rd, 32'h0000_0911);
    check({30'h0, seen}, 32'h0);
    // Every operand code on both selects; off ignores the second
    for (int c = 1; c <= 13; c++)
    begin
      ahb(1'b1, hcoc_pkg::OFS_LINE1_CFG, cfg(4'(c), 4'(c % 13 + 1), 2'h1,
          2'h2));
      ahb(1'b1, hcoc_pkg::OFS_LINE2_CFG, cfg(4'(c % 13 + 1), 4'(c), 2'h3,
          2'h1));
      judge(13'(1 << (c - 1)), 2'b01);
      judge(13'(1 << (c % 13)), 2'b00);
      judge(13'h0, 2'b10);
    end
    // Line 1 fixed as active-low AND of bin 1 and bin 2
    ahb(1'b1, hcoc_pkg::OFS_LINE1_CFG, cfg(4'h2, 4'h1, 2'h2, 2'h1));
    // Every operator and polarity on line 2 over all inputs
    for (int o = 1; o <= 3; o++)
      for (int p = 1; p <= 2; p++)
      begin
        ahb(1'b1, hcoc_pkg::OFS_LINE2_CFG, cfg(4'h1, 4'h2, 2'(o), 2'(p)));
        ahb(1'b0, hcoc_pkg::OFS_LINE2_CFG, 32'h0);
        check(rd, cfg(4'h1, 4'h2, 2'(o), 2'(p)));
        for (int j = 0; j < 4; j++)
        begin
          a = j[0];
          b = j[1];
          cond = (o == 1) ? a : (o == 2) ? (a & b) : (a | b);
          exp = {(p == 2) ? cond : ~cond, ~(a & b)};
          judge(13'(j), exp);
        end
      end
    // Status shows the last judgement and line levels; read only
    ahb(1'b1, hcoc_pkg::OFS_STATUS, 32'hffff_ffff);
    ahb(1'b0, hcoc_pkg::OFS_STATUS, 32'h0);
    check(rd, {14'h0, exp, 3'h0, 13'h3});
    // Illegal codes leave every field alone
    ahb(1'b1, hcoc_pkg::OFS_LINE1_CFG, cfg(4'h0, 4'he, 2'h0, 2'h3));
    ahb(1'b0, hcoc_pkg::OFS_LINE1_CFG, 32'h0);
    check(rd, cfg(4'h2, 4'h1, 2'h2, 2'h1));
    // Unmapped place reads zero after a write
    ahb(1'b1, 32'h0000_0010, 32'hffff_ffff);
    ahb(1'b0, 32'h0000_0010, 32'h0);
    check(rd, 32'h0);
    summarize();
  end
endmodule : tb_handler_custom_output_combiner
